// ==== hw/smf_pkg.sv ====
package smf_pkg;
	// ==========================================
	// Register map
	localparam logic [7:0] SMF_ADDR_CONTROL = 8'hdf;
	localparam logic [7:0] SMF_ADDR_IRQ_STATUS = 8'he0;
	localparam logic [7:0] SMF_ADDR_IRQ_MASK = 8'he1;
	localparam logic [7:0] SMF_CONTROL_RESET = 8'hde;
	localparam logic [7:0] SMF_MASK_RESET = 8'h00;
	// ==========================================
	// Control fields
	localparam int SMF_BIT_DIG_OK = 7;
	localparam int SMF_BIT_ANA_OK = 6;
	localparam int SMF_BIT_FLAG = 5;
	localparam int SMF_BIT_DTRIP_HI = 4;
	localparam int SMF_BIT_DTRIP_LO = 3;
	localparam int SMF_BIT_ATRIP_HI = 2;
	localparam int SMF_BIT_ATRIP_LO = 1;
	localparam int SMF_BIT_ENABLE = 0;
	// ==========================================
	// Trip select codes
	localparam logic [1:0] SMF_TRIP_4V63 = 2'h0;
	localparam logic [1:0] SMF_TRIP_3V08 = 2'h1;
	localparam logic [1:0] SMF_TRIP_2V93 = 2'h2;
	localparam logic [1:0] SMF_TRIP_2V63 = 2'h3;
	// ==========================================
	// Interrupt status bits
	localparam int SMF_EV_SET = 0;
	localparam int SMF_EV_CLR = 1;
	localparam int SMF_EV_NUM = 2;
	// ==========================================
	// Timing
	localparam longint SMF_CLK_HZ = 250000000;
	localparam longint SMF_RECOVER_MS = 250;
	localparam longint SMF_RECOVER_CYC = SMF_CLK_HZ * SMF_RECOVER_MS / 1000;
	localparam int SMF_GLITCH_CYC = 16;
	typedef enum logic [1:0] {
		SMF_ST_IDLE = 2'h0,
		SMF_ST_LOW = 2'h1,
		SMF_ST_RECOVER = 2'h3
	} smf_state_t;
endpackage : smf_pkg

// ==== hw/smf_supply_monitor.sv ====
// Chosen here: the Avalon-MM register port.
`timescale 1ns/100ps
module smf_supply_monitor #(
	parameter longint RECOVER_CYC = smf_pkg::SMF_RECOVER_CYC,
	parameter int GLITCH_CYC = smf_pkg::SMF_GLITCH_CYC,
	parameter bit HIGH_VOLT_PART = 1'b0
) (
	input wire logic clk_sys_i,
	input wire logic reset_i,
	input wire logic [7:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	input wire logic digital_cmp_i,
	input wire logic analog_cmp_i,
	input wire logic secondary_irq_enable_priority_i,
	output logic [1:0] digital_trip_select_o,
	output logic [1:0] analog_trip_select_o,
	output logic monitor_enable_o,
	output logic low_supply_irq_o,
	output logic irq_o
);
	import smf_pkg::*;

	// ==========================================
	// Synchronisers and glitch filter
	logic [1:0] dig_sync_ff, ana_sync_ff;
	logic [$clog2(GLITCH_CYC+1)-1:0] dig_cnt_ff, ana_cnt_ff;
	logic digital_supply_ok_ff, analog_supply_ok_ff;
	logic [7:0] control_ff;
	logic enable;

	assign enable = control_ff[SMF_BIT_ENABLE];

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			dig_sync_ff <= 2'h3;
			ana_sync_ff <= 2'h3;
		end else begin
			dig_sync_ff <= {dig_sync_ff[0], digital_cmp_i};
			ana_sync_ff <= {ana_sync_ff[0], analog_cmp_i};
		end
	end

	// A new level must hold GLITCH_CYC cycles before it is believed
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			dig_cnt_ff <= '0;
			ana_cnt_ff <= '0;
			digital_supply_ok_ff <= 1'b1;
			analog_supply_ok_ff <= 1'b1;
		end else begin
			if (dig_sync_ff[1] == digital_supply_ok_ff) begin
				dig_cnt_ff <= '0;
			end else if (dig_cnt_ff == ($bits(dig_cnt_ff))'(GLITCH_CYC - 1)) begin
				dig_cnt_ff <= '0;
				digital_supply_ok_ff <= dig_sync_ff[1];
			end else begin
				dig_cnt_ff <= dig_cnt_ff + 1'b1;
			end
			if (ana_sync_ff[1] == analog_supply_ok_ff) begin
				ana_cnt_ff <= '0;
			end else if (ana_cnt_ff == ($bits(ana_cnt_ff))'(GLITCH_CYC - 1)) begin
				ana_cnt_ff <= '0;
				analog_supply_ok_ff <= ana_sync_ff[1];
			end else begin
				ana_cnt_ff <= ana_cnt_ff + 1'b1;
			end
		end
	end

	// ==========================================
	// Supply low decision
	logic dig_low, ana_low, any_low;
	// On the high-voltage part a digital dip means power-on reset, never a flag
	assign dig_low = enable && !HIGH_VOLT_PART && !digital_supply_ok_ff;
	assign ana_low = enable && !analog_supply_ok_ff;
	assign any_low = dig_low || ana_low;

	// ==========================================
	// Bus decode
	logic wr_ctl, rd_stat, wr_mask, rd_take, rd_ack_ff;
	// First cycle of a read waits while the read data are registered
	assign rd_take = avs_read_i && !rd_ack_ff;
	assign avs_waitrequest_o = rd_take;
	assign wr_ctl = avs_write_i && avs_byteenable_i[0] && (avs_address_i == SMF_ADDR_CONTROL);
	assign wr_mask = avs_write_i && avs_byteenable_i[0] && (avs_address_i == SMF_ADDR_IRQ_MASK);
	assign rd_stat = rd_take && (avs_address_i == SMF_ADDR_IRQ_STATUS);

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			rd_ack_ff <= 1'b0;
		end else begin
			rd_ack_ff <= rd_take;
		end
	end

	// ==========================================
	// Control register: trip selects and enable
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			control_ff <= SMF_CONTROL_RESET;
		end else if (wr_ctl) begin
			control_ff[SMF_BIT_DTRIP_HI:SMF_BIT_DTRIP_LO] <= avs_writedata_i[4:3];
			control_ff[SMF_BIT_ATRIP_HI:SMF_BIT_ATRIP_LO] <= avs_writedata_i[2:1];
			control_ff[SMF_BIT_ENABLE] <= avs_writedata_i[0];
		end
	end
	assign digital_trip_select_o = control_ff[SMF_BIT_DTRIP_HI:SMF_BIT_DTRIP_LO];
	assign analog_trip_select_o = control_ff[SMF_BIT_ATRIP_HI:SMF_BIT_ATRIP_LO];
	assign monitor_enable_o = enable;

	// ==========================================
	// Recovery sequencer and low-supply flag
	smf_state_t state_ff;
	logic [$clog2(RECOVER_CYC+1)-1:0] rec_cnt_ff;
	logic flag_ff, rec_done;
	assign rec_done = (state_ff == SMF_ST_RECOVER)
		&& (rec_cnt_ff == ($bits(rec_cnt_ff))'(RECOVER_CYC - 1));

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			state_ff <= SMF_ST_IDLE;
			rec_cnt_ff <= '0;
		end else begin
			unique case (state_ff)
				SMF_ST_IDLE: begin
					rec_cnt_ff <= '0;
					if (any_low) begin
						state_ff <= SMF_ST_LOW;
					end
				end
				SMF_ST_LOW: begin
					rec_cnt_ff <= '0;
					if (!any_low) begin
						state_ff <= SMF_ST_RECOVER;
					end
				end
				SMF_ST_RECOVER: begin
					if (any_low) begin
						state_ff <= SMF_ST_LOW;
						rec_cnt_ff <= '0;
					end else if (rec_done) begin
						state_ff <= SMF_ST_IDLE;
						rec_cnt_ff <= '0;
					end else begin
						rec_cnt_ff <= rec_cnt_ff + 1'b1;
					end
				end
				default: begin
					state_ff <= SMF_ST_IDLE;
					rec_cnt_ff <= '0;
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			flag_ff <= SMF_CONTROL_RESET[SMF_BIT_FLAG];
		end else if (any_low) begin
			flag_ff <= 1'b1;
		end else if (wr_ctl) begin
			flag_ff <= avs_writedata_i[SMF_BIT_FLAG];
		end else if (rec_done) begin
			flag_ff <= 1'b0;
		end
	end

	assign low_supply_irq_o = flag_ff && secondary_irq_enable_priority_i;

	// ==========================================
	// Interrupt status, mask and read data
	logic [SMF_EV_NUM-1:0] irq_stat_ff, irq_mask_ff, events;
	logic flag_q_ff;
	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			flag_q_ff <= 1'b0;
		end else begin
			flag_q_ff <= flag_ff;
		end
	end
	assign events[SMF_EV_SET] = flag_ff && !flag_q_ff;
	assign events[SMF_EV_CLR] = !flag_ff && flag_q_ff;

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_stat_ff <= '0;
		end else if (rd_stat) begin
			irq_stat_ff <= events;
		end else begin
			irq_stat_ff <= irq_stat_ff | events;
		end
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			irq_mask_ff <= SMF_MASK_RESET[SMF_EV_NUM-1:0];
		end else if (wr_mask) begin
			irq_mask_ff <= avs_writedata_i[SMF_EV_NUM-1:0];
		end
	end
	assign irq_o = |(irq_stat_ff & irq_mask_ff);

	logic [7:0] ctl_view;
	always_comb begin
		ctl_view = control_ff;
		ctl_view[SMF_BIT_DIG_OK] = digital_supply_ok_ff;
		ctl_view[SMF_BIT_ANA_OK] = analog_supply_ok_ff;
		ctl_view[SMF_BIT_FLAG] = flag_ff;
	end

	always_ff @(posedge clk_sys_i or posedge reset_i) begin
		if (reset_i) begin
			avs_readdata_o <= '0;
		end else if (rd_take) begin
			unique case (avs_address_i)
				SMF_ADDR_CONTROL: avs_readdata_o <= {24'h000000, ctl_view};
				SMF_ADDR_IRQ_STATUS: avs_readdata_o <= {30'h0, irq_stat_ff};
				SMF_ADDR_IRQ_MASK: avs_readdata_o <= {30'h0, irq_mask_ff};
				default: avs_readdata_o <= '0;
			endcase
		end
	end

	// ==========================================
	// Checks
	property p_flag_when_low;
		@(posedge clk_sys_i) disable iff (reset_i) any_low |=> flag_ff;
	endproperty
	a_flag_when_low: assert property (p_flag_when_low) else $error("flag not set while low");

	property p_no_clear_low;
		@(posedge clk_sys_i) disable iff (reset_i)
			(any_low && wr_ctl && !avs_writedata_i[SMF_BIT_FLAG]) |=> flag_ff;
	endproperty
	a_no_clear_low: assert property (p_no_clear_low) else $error("flag cleared while low");

	property p_write_takes;
		@(posedge clk_sys_i) disable iff (reset_i)
			(!any_low && wr_ctl) |=> (flag_ff == $past(avs_writedata_i[SMF_BIT_FLAG]));
	endproperty
	a_write_takes: assert property (p_write_takes) else $error("flag write lost");

	property p_rec_clear;
		@(posedge clk_sys_i) disable iff (reset_i) (rec_done && !any_low && !wr_ctl) |=> !flag_ff;
	endproperty
	a_rec_clear: assert property (p_rec_clear) else $error("flag not cleared at timeout");

	property p_relapse;
		@(posedge clk_sys_i) disable iff (reset_i)
			(state_ff == SMF_ST_RECOVER && any_low) |=> (state_ff == SMF_ST_LOW && rec_cnt_ff == '0);
	endproperty
	a_relapse: assert property (p_relapse) else $error("recovery not aborted");

	property p_irq_gate;
		@(posedge clk_sys_i) disable iff (reset_i)
			low_supply_irq_o == (flag_ff && secondary_irq_enable_priority_i);
	endproperty
	a_irq_gate: assert property (p_irq_gate) else $error("irq gating wrong");

	property p_glitch;
		@(posedge clk_sys_i) disable iff (reset_i)
			$fell(digital_supply_ok_ff) |-> $past(!dig_sync_ff[1], 2);
	endproperty
	a_glitch: assert property (p_glitch) else $error("glitch passed filter");

	property p_disabled;
		@(posedge clk_sys_i) disable iff (reset_i)
			(!enable && !wr_ctl && !flag_ff) |=> !flag_ff;
	endproperty
	a_disabled: assert property (p_disabled) else $error("flag set while disabled");

	property p_ana_glitch;
		@(posedge clk_sys_i) disable iff (reset_i)
			$fell(analog_supply_ok_ff) |-> $past(!ana_sync_ff[1], 2);
	endproperty
	a_ana_glitch: assert property (p_ana_glitch) else $error("analog glitch passed");

	property p_dig_rise;
		@(posedge clk_sys_i) disable iff (reset_i)
			$rose(digital_supply_ok_ff) |-> $past(dig_sync_ff[1], 2);
	endproperty
	a_dig_rise: assert property (p_dig_rise) else $error("digital ok rose early");

	property p_ana_rise;
		@(posedge clk_sys_i) disable iff (reset_i)
			$rose(analog_supply_ok_ff) |-> $past(ana_sync_ff[1], 2);
	endproperty
	a_ana_rise: assert property (p_ana_rise) else $error("analog ok rose early");

	property p_rec_count;
		@(posedge clk_sys_i) disable iff (reset_i)
			(state_ff == SMF_ST_RECOVER && !any_low && !rec_done)
			|=> (rec_cnt_ff == $past(rec_cnt_ff) + 1'b1);
	endproperty
	a_rec_count: assert property (p_rec_count) else $error("recovery count stalled");

	property p_no_early_clear;
		@(posedge clk_sys_i) disable iff (reset_i)
			(flag_ff && !wr_ctl && !rec_done) |=> flag_ff;
	endproperty
	a_no_early_clear: assert property (p_no_early_clear) else $error("flag cleared early");

	// ==========================================
	// Bus and status checks
	property p_stat_rose;
		@(posedge clk_sys_i) disable iff (reset_i)
			events[SMF_EV_SET] |=> irq_stat_ff[SMF_EV_SET];
	endproperty
	a_stat_rose: assert property (p_stat_rose) else $error("rise event not recorded");

	property p_stat_sticky;
		@(posedge clk_sys_i) disable iff (reset_i)
			(irq_stat_ff[SMF_EV_SET] && !rd_stat) |=> irq_stat_ff[SMF_EV_SET];
	endproperty
	a_stat_sticky: assert property (p_stat_sticky) else $error("status bit lost");

	property p_read_wait;
		@(posedge clk_sys_i) disable iff (reset_i)
			(avs_read_i && !$past(avs_read_i)) |-> avs_waitrequest_o;
	endproperty
	a_read_wait: assert property (p_read_wait) else $error("read accepted without wait");

	property p_read_hold;
		@(posedge clk_sys_i) disable iff (reset_i)
			(avs_read_i && !avs_waitrequest_o) |=> $stable(avs_readdata_o);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data moved at accept");
endmodule : smf_supply_monitor

// ==== tb/testbench.sv ====
`timescale 1ns/100ps
module testbench;
	import smf_pkg::*;
	// ==========================================
	// Stimulus and observation
	logic clk_sys = 1'b0;
	logic reset = 1'b1;
	logic [7:0] address = 8'h00;
	logic read = 1'b0;
	logic write = 1'b0;
	logic [31:0] writedata = 32'h0;
	logic [3:0] byteenable = 4'hf;
	logic [31:0] readdata;
	logic waitrequest;
	logic dig_ok = 1'b1;
	logic ana_ok = 1'b1;
	logic sec_en = 1'b0;
	logic [1:0] dtrip;
	logic [1:0] atrip;
	logic mon_en;
	logic low_irq;
	logic irq;
	logic hv_irq;
	int failures = 0;
	int compares = 0;
	int cycles = 0;
	logic [7:0] rnd = 8'h43;
	logic [7:0] v;
	logic [31:0] rdat;
	always #2 clk_sys = ~clk_sys;
	smf_supply_monitor #(.RECOVER_CYC(100), .GLITCH_CYC(16), .HIGH_VOLT_PART(1'b0)) dut (
		.clk_sys_i(clk_sys), .reset_i(reset), .avs_address_i(address), .avs_read_i(read),
		.avs_write_i(write), .avs_writedata_i(writedata), .avs_byteenable_i(byteenable),
		.avs_readdata_o(readdata), .avs_waitrequest_o(waitrequest), .digital_cmp_i(dig_ok),
		.analog_cmp_i(ana_ok), .secondary_irq_enable_priority_i(sec_en),
		.digital_trip_select_o(dtrip), .analog_trip_select_o(atrip),
		.monitor_enable_o(mon_en), .low_supply_irq_o(low_irq), .irq_o(irq));
	smf_supply_monitor #(.RECOVER_CYC(100), .GLITCH_CYC(16), .HIGH_VOLT_PART(1'b1)) dut_hv (
		.clk_sys_i(clk_sys), .reset_i(reset), .avs_address_i(address), .avs_read_i(read),
		.avs_write_i(write), .avs_writedata_i(writedata), .avs_byteenable_i(byteenable),
		.avs_readdata_o(), .avs_waitrequest_o(), .digital_cmp_i(dig_ok),
		.analog_cmp_i(ana_ok), .secondary_irq_enable_priority_i(sec_en),
		.digital_trip_select_o(), .analog_trip_select_o(),
		.monitor_enable_o(), .low_supply_irq_o(hv_irq), .irq_o());
	// ==========================================
	// Helpers
	function automatic logic [7:0] lfsr(input logic [7:0] x);
		return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
	endfunction : lfsr
	function automatic logic [31:0] exp_ctl(input logic d, input logic a, input logic f,
		input logic [4:0] low);
		return {24'h0, d, a, f, low};
	endfunction : exp_ctl
	task automatic summarize();
		if (failures == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			failures++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk
	task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] be);
		@(posedge clk_sys);
		address <= a;
		writedata <= {24'h0, d};
		byteenable <= be;
		write <= 1'b1;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		write <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys);
		address <= a;
		read <= 1'b1;
		do @(posedge clk_sys); while (waitrequest !== 1'b0);
		d = readdata;
		read <= 1'b0;
	endtask : rd
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys);
	endtask : cyc
	always @(posedge clk_sys) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			summarize();
		end
	end
	// ==========================================
	// Main sequence
	initial begin
		cyc(4);
		reset <= 1'b0;
		rd(SMF_ADDR_CONTROL, rdat);
		chk("control reset", rdat, 32'h0000_00de);
		rd(SMF_ADDR_IRQ_MASK, rdat);
		chk("mask reset", rdat, 32'h0);
		chk("trips reset", {dtrip, atrip, mon_en}, 32'h1e);
		for (int i = 0; i < 12; i++) begin
			v = (i < 4) ? {3'b000, i[1:0], ~i[1:0], 1'b1} : (rnd & 8'h1f);
			rnd = lfsr(rnd);
			wr(SMF_ADDR_CONTROL, v | 8'hc0, 4'h1);
			rd(SMF_ADDR_CONTROL, rdat);
			chk("control rw", rdat, exp_ctl(1'b1, 1'b1, 1'b0, v[4:0]));
			chk("dtrip", dtrip, v[4:3]);
			chk("atrip", atrip, v[2:1]);
			chk("enable", mon_en, v[0]);
		end
		wr(SMF_ADDR_CONTROL, 8'h1e, 4'h1);
		dig_ok <= 1'b0;
		cyc(30);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("disabled low", rdat, exp_ctl(1'b0, 1'b1, 1'b0, 5'h1e));
		dig_ok <= 1'b1;
		cyc(30);
		rd(SMF_ADDR_IRQ_STATUS, rdat);
		chk("status idle", rdat, 32'h0);
		wr(SMF_ADDR_CONTROL, 8'h1f, 4'h1);
		wr(SMF_ADDR_IRQ_MASK, 8'h01, 4'h1);
		wr(8'he2, 8'hff, 4'h1);
		wr(SMF_ADDR_CONTROL, 8'h00, 4'h0);
		rd(8'he2, rdat);
		chk("unmapped", rdat, 32'h0);
		ana_ok <= 1'b0;
		cyc(5);
		ana_ok <= 1'b1;
		cyc(30);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("glitch", rdat, exp_ctl(1'b1, 1'b1, 1'b0, 5'h1f));
		chk("irq glitch", irq, 1'b0);
		ana_ok <= 1'b0;
		cyc(30);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("analog low", rdat, exp_ctl(1'b1, 1'b0, 1'b1, 5'h1f));
		chk("cpu irq gated", low_irq, 1'b0);
		sec_en <= 1'b1;
		cyc(1);
		chk("cpu irq", low_irq, 1'b1);
		chk("hv analog", hv_irq, 1'b1);
		chk("irq set", irq, 1'b1);
		wr(SMF_ADDR_CONTROL, 8'h1f, 4'h1);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("clear blocked", rdat, exp_ctl(1'b1, 1'b0, 1'b1, 5'h1f));
		rd(SMF_ADDR_IRQ_STATUS, rdat);
		chk("status rose", rdat, 32'h1);
		chk("irq cleared", irq, 1'b0);
		ana_ok <= 1'b1;
		cyc(60);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("recover wait", rdat, exp_ctl(1'b1, 1'b1, 1'b1, 5'h1f));
		dig_ok <= 1'b0;
		cyc(25);
		dig_ok <= 1'b1;
		cyc(90);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("relapse restart", rdat, exp_ctl(1'b1, 1'b1, 1'b1, 5'h1f));
		chk("hv ignores digital", hv_irq, 1'b0);
		cyc(40);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("recovered", rdat, exp_ctl(1'b1, 1'b1, 1'b0, 5'h1f));
		chk("cpu irq off", low_irq, 1'b0);
		rd(SMF_ADDR_IRQ_STATUS, rdat);
		chk("status fell", rdat, 32'h2);
		wr(SMF_ADDR_CONTROL, 8'h3f, 4'h1);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("sw set", rdat, exp_ctl(1'b1, 1'b1, 1'b1, 5'h1f));
		wr(SMF_ADDR_CONTROL, 8'h1f, 4'h1);
		rd(SMF_ADDR_CONTROL, rdat);
		chk("sw clear", rdat, exp_ctl(1'b1, 1'b1, 1'b0, 5'h1f));
		summarize();
	end
endmodule : testbench
